// File: rtl/sflash_pkg.sv
// sflash_pkg: opcodes, status layout, timing and frame carrier
// What this block does
// - write-disable clears the write latch flag
// - latch flag clears at reset and non-volatile write completion
// - 05h/35h return status one/two, msb first
// - status reads anytime, byte repeats until deselect
// - writes touch only bits 7..2 and 14..8
// - otp lock bits and volatile mode-hi clear only at reset
// - non-volatile status write needs latch flag set
// - 50h then 01h writes volatile copy only
// - status write needs exactly 8 or 16 data bits
// - eight-bit write clears invert, quad bits; mode-hi too unless volatile
// - non-volatile write: busy cycle, then latch cleared
// - volatile write settles quickly, busy stays low
// - power-up reloads status from non-volatile copy
// - 03h: opcode, 24-bit address, byte out msb-first
// - array reads auto-increment until deselect
// - plain read while busy is ignored
// - 0Bh has eight dummy clocks before data
// - 3Bh returns data on two lanes
// - 6Bh four lanes, only with quad permit
// - write-enable sets the write latch flag
// - dual: odd bits lane 1, even lane 0
// - quad: upper nibble first on lanes 3..0
package sflash_pkg;
    // ==============================
    // opcodes
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
    localparam logic [7:0] OP_WR_STATUS  = 8'h01;
    localparam logic [7:0] OP_RD_STAT1   = 8'h05;
    localparam logic [7:0] OP_RD_STAT2   = 8'h35;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_FAST       = 8'h0b;
    localparam logic [7:0] OP_DUAL       = 8'h3b;
    localparam logic [7:0] OP_QUAD       = 8'h6b;
    // ==============================
    // status layout
    localparam int          BIT_BUSY     = 0;
    localparam int          BIT_LATCH    = 1;
    localparam int          BIT_MODE_HI  = 8;
    localparam int          BIT_QUAD     = 9;
    localparam int          BIT_OTP_LO   = 11;
    localparam int          BIT_INVERT   = 14;
    localparam logic [15:0] WR_MASK      = 16'h7ffc;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // ==============================
    // frame bit counts
    localparam logic [5:0] CNT_OPC  = 6'h08;
    localparam logic [5:0] CNT_ADDR = 6'h20;
    localparam logic [5:0] CNT_FAST = 6'h28;
    localparam logic [5:0] CNT_WR8  = 6'h10;
    localparam logic [5:0] CNT_WR16 = 6'h18;
    localparam logic [5:0] CNT_MAX  = 6'h3f;
    // ==============================
    // timing
    localparam int CLK_PERIOD_NS          = 100;
    localparam int WRITE_CYCLE_TIME_NS    = 1000000;
    localparam int WRITE_CYCLE_CYCLES     = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VOLATILE_SETTLE_TIME_NS = 50;
    localparam int SETTLE_FLOOR           = VOLATILE_SETTLE_TIME_NS / CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES          = (SETTLE_FLOOR < 1) ? 1 : SETTLE_FLOOR;
    // ==============================
    // types
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_NVW  = 3'h2,
        ST_VSET = 3'h4
    } core_e;

    typedef struct packed
    {
        logic [7:0]  opcode;
        logic [5:0]  bits;
        logic [15:0] data;
    } frame_s;
endpackage : sflash_pkg

// File: rtl/serial_flash_cmd.sv
// serial_flash_cmd: spi flash status and read command engine
`timescale 1ns/10ps
module serial_flash_cmd
    import sflash_pkg::*;
#(
    parameter int         WRITE_CYCLES = WRITE_CYCLE_CYCLES,
    parameter logic [7:0] ARRAY_SEED   = 8'h5a
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    output logic             busy_o,
    output logic      [15:0] status_o
);

    localparam int SETTLE_N = SETTLE_CYCLES;

    // ==============================
    // functions
    function automatic logic [5:0] data_start(input logic [7:0] op);
        case (op)
            OP_RD_STAT1, OP_RD_STAT2: return CNT_OPC;
            OP_READ:                  return CNT_ADDR;
            OP_FAST, OP_DUAL,
            OP_QUAD:                  return CNT_FAST;
            default:                  return 6'h00;
        endcase
    endfunction : data_start

    function automatic logic [2:0] lane_width(input logic [7:0] op);
        case (op)
            OP_DUAL: return 3'h2;
            OP_QUAD: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction : lane_width

    function automatic logic [7:0] array_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ ARRAY_SEED;
    endfunction : array_byte

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic        two,
                                          input logic        vol);
        logic [15:0] n;
        n = two ? {d[7:0], d[15:8]} : {old[15:8], d[7:0]};
        if (!two)
        begin
            n[BIT_INVERT]  = 1'b0;
            n[BIT_QUAD]    = 1'b0;
            n[BIT_MODE_HI] = 1'b0;
        end
        n = (n & WR_MASK) | (old & ~WR_MASK);
        n[BIT_OTP_LO+2:BIT_OTP_LO] = n[BIT_OTP_LO+2:BIT_OTP_LO] | old[BIT_OTP_LO+2:BIT_OTP_LO];
        if (vol)
        begin
            n[BIT_MODE_HI] = n[BIT_MODE_HI] | old[BIT_MODE_HI];
        end
        return n;
    endfunction : merge

    // ==============================
    // link domain: input shifting
    logic        link_rst;
    logic [5:0]  cnt;
    logic [23:0] rx;
    logic [23:0] base_addr;
    logic        ftog;
    frame_s      fr;
    logic [15:0] snap;

    assign link_rst = rst_i | cs_n_i;

    always_ff @(posedge sclk_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            cnt <= 6'h00;
        end
        else if (cnt != CNT_MAX)
        begin
            cnt <= cnt + 6'h01;
        end
    end

    // frame capture survives deselect so the core can read it
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx        <= 24'h000000;
            base_addr <= 24'h000000;
            ftog      <= 1'b0;
            fr        <= '0;
        end
        else
        begin
            rx      <= {rx[22:0], io_i[0]};
            fr.bits <= (cnt == CNT_MAX) ? cnt : cnt + 6'h01;
            fr.data <= {rx[14:0], io_i[0]};
            if (cnt == 6'h00)
            begin
                ftog <= ~ftog;
            end
            if (cnt == CNT_OPC - 6'h01)
            begin
                fr.opcode <= {rx[6:0], io_i[0]};
            end
            if (cnt == CNT_ADDR - 6'h01)
            begin
                base_addr <= {rx[22:0], io_i[0]};
            end
        end
    end

    // ==============================
    // link domain: output shifting
    logic [5:0]  start;
    logic [2:0]  lanes;
    logic [2:0]  last;
    logic        is_stat;
    logic        go;
    logic [2:0]  sub;
    logic [23:0] nbytes;
    logic [7:0]  tx;
    logic [7:0]  load;
    logic [7:0]  cur;

    assign start   = data_start(fr.opcode);
    assign lanes   = lane_width(fr.opcode);
    assign is_stat = (fr.opcode == OP_RD_STAT1) || (fr.opcode == OP_RD_STAT2);
    assign last    = (lanes == 3'h4) ? 3'h1 : (lanes == 3'h2) ? 3'h3 : 3'h7;

    always_comb
    begin
        go = (start != 6'h00) && (cnt >= start);
        if (snap[BIT_BUSY] && !is_stat)
        begin
            go = 1'b0;
        end
        if ((fr.opcode == OP_QUAD) && !snap[BIT_QUAD])
        begin
            go = 1'b0;
        end
    end

    always_comb
    begin
        if (fr.opcode == OP_RD_STAT2)
        begin
            load = snap[15:8];
        end
        else if (fr.opcode == OP_RD_STAT1)
        begin
            load = snap[7:0];
        end
        else
        begin
            load = array_byte(base_addr + nbytes);
        end
        cur = (sub == 3'h0) ? load : tx;
    end

    always_ff @(negedge sclk_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            tx      <= 8'h00;
            sub     <= 3'h0;
            nbytes  <= 24'h000000;
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
        end
        else if (go)
        begin
            tx  <= cur << lanes;
            sub <= (sub == last) ? 3'h0 : sub + 3'h1;
            if ((sub == 3'h0) && !is_stat)
            begin
                nbytes <= nbytes + 24'h000001;
            end
            case (lanes)
                3'h4:
                begin
                    io_o    <= cur[7:4];
                    io_oe_o <= 4'hf;
                end
                3'h2:
                begin
                    io_o    <= {2'h0, cur[7], cur[6]};
                    io_oe_o <= 4'h3;
                end
                default:
                begin
                    io_o    <= {2'h0, cur[7], 1'b0};
                    io_oe_o <= 4'h2;
                end
            endcase
        end
        else
        begin
            io_oe_o <= 4'h0;
        end
    end

    // ==============================
    // core domain: frame end detection
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic tog_meta;
    logic tog_sync;
    logic tog_done;
    logic frame_end;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_meta  <= 1'b1;
            cs_sync  <= 1'b1;
            cs_prev  <= 1'b1;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_done <= 1'b0;
        end
        else
        begin
            cs_meta  <= cs_n_i;
            cs_sync  <= cs_meta;
            cs_prev  <= cs_sync;
            tog_meta <= ftog;
            tog_sync <= tog_meta;
            if (frame_end)
            begin
                tog_done <= tog_sync;
            end
        end
    end

    // a deselect with no clocks in it carries no frame
    assign frame_end = cs_sync && !cs_prev && (tog_sync != tog_done);

    // ==============================
    // core domain: command decode
    core_e       state;
    logic [23:0] tmr;
    logic        busy;
    logic        write_latch_flag;
    logic        vol_arm;
    logic        boot;
    logic [15:0] stat;
    logic [15:0] nv;
    logic [15:0] pend;
    logic [15:0] new_stat;
    logic        take;
    logic        f8;
    logic        len_ok;
    logic        do_wren;
    logic        do_wrdis;
    logic        do_arm;
    logic        do_sw;
    logic        do_vol;
    logic        do_nv;
    logic        done;

    assign busy     = (state == ST_NVW);
    assign take     = frame_end && (state == ST_IDLE);
    assign f8       = (fr.bits == CNT_OPC);
    assign len_ok   = (fr.bits == CNT_WR8) || (fr.bits == CNT_WR16);
    assign do_wren  = take && f8 && (fr.opcode == OP_WR_ENABLE);
    assign do_wrdis = take && f8 && (fr.opcode == OP_WR_DISABLE);
    assign do_arm   = take && f8 && (fr.opcode == OP_VOL_ENABLE);
    assign do_sw    = take && len_ok && (fr.opcode == OP_WR_STATUS);
    assign do_vol   = do_sw && vol_arm;
    assign do_nv    = do_sw && !vol_arm && write_latch_flag;
    assign done     = (tmr == 24'h000000);
    assign new_stat = merge(stat, fr.data, fr.bits == CNT_WR16, vol_arm);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            tmr   <= 24'h000000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (do_nv)
                    begin
                        state <= ST_NVW;
                        tmr   <= 24'(WRITE_CYCLES - 1);
                    end
                    else if (do_vol)
                    begin
                        state <= ST_VSET;
                        tmr   <= 24'(SETTLE_CYCLES - 1);
                    end
                end
                ST_NVW, ST_VSET:
                begin
                    if (done)
                    begin
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        tmr <= tmr - 24'h000001;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            write_latch_flag <= 1'b0;
        end
        else if (do_wren)
        begin
            write_latch_flag <= 1'b1;
        end
        else if (do_wrdis)
        begin
            write_latch_flag <= 1'b0;
        end
        else if (busy && done)
        begin
            write_latch_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vol_arm <= 1'b0;
        end
        else if (frame_end)
        begin
            vol_arm <= do_arm;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot <= 1'b1;
            stat <= STATUS_RESET;
            nv   <= STATUS_RESET;
            pend <= STATUS_RESET;
        end
        else if (boot)
        begin
            boot <= 1'b0;
            stat <= nv;
        end
        else if (do_nv)
        begin
            stat <= new_stat;
            nv   <= new_stat;
        end
        else if (do_vol)
        begin
            pend <= new_stat;
        end
        else if ((state == ST_VSET) && done)
        begin
            stat <= pend;
        end
    end

    // snapshot only moves between frames, so the link sees a steady word
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            snap <= STATUS_RESET;
        end
        else if (cs_sync)
        begin
            snap <= status_o;
        end
    end

    assign status_o = {stat[15:2], write_latch_flag, busy};
    assign busy_o   = busy;

    // ==============================
    // assertions
    a_wr_disable: assert property (@(posedge clk_i) disable iff (rst_i)
        do_wrdis |=> !write_latch_flag)
        else $error("write disable left the latch flag set");

    a_wr_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        do_wren |=> write_latch_flag)
        else $error("write enable did not set the latch flag");

    a_nv_start: assert property (@(posedge clk_i) disable iff (rst_i)
        do_nv |=> busy && write_latch_flag)
        else $error("non-volatile write did not start a busy cycle");

    a_busy_end: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy) |-> !write_latch_flag)
        else $error("latch flag still set after write cycle");

    a_no_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_sw && !write_latch_flag && !vol_arm) |=> (state == ST_IDLE) && (stat == $past(stat)))
        else $error("status write accepted without latch flag");

    a_bad_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && (fr.opcode == OP_WR_STATUS) && !len_ok) |=> (state == ST_IDLE) && $stable(stat))
        else $error("status write of wrong length took effect");

    a_vol_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        do_vol |=> (!busy throughout (##SETTLE_N (state == ST_IDLE))))
        else $error("volatile write raised busy or did not settle");

    a_short_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_vol && (fr.bits == CNT_WR8)) |=> ##SETTLE_N (!stat[BIT_INVERT] && !stat[BIT_QUAD]))
        else $error("eight-bit write left invert or quad bit set");

    a_otp_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        !boot |=> (($past(stat[13:11]) & ~stat[13:11]) == 3'h0))
        else $error("a lock bit was cleared");

    a_ro_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        do_sw |=> (stat[15] == $past(stat[15])) && (stat[1:0] == 2'h0))
        else $error("read-only status bit changed");

    a_quad_gate: assert property (@(negedge sclk_i) disable iff (link_rst)
        ((cnt >= CNT_OPC) && (fr.opcode == OP_QUAD) && !snap[BIT_QUAD]) |=> (io_oe_o == 4'h0))
        else $error("quad read answered without quad permit");

    a_busy_read: assert property (@(negedge sclk_i) disable iff (link_rst)
        ((cnt >= CNT_OPC) && (fr.opcode == OP_READ) && snap[BIT_BUSY]) |=> (io_oe_o == 4'h0))
        else $error("array read answered while busy");

endmodule : serial_flash_cmd

// File: tb/spi_host_model.sv
// spi_host_model: behavioural spi host that frames commands and collects lane data
`timescale 1ns/10ps
module spi_host_model
(
    input  wire logic [3:0] dev_io_i,
    input  wire logic [3:0] dev_oe_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic      [3:0] lane_o
);
    logic       drive0;
    logic       host_bit;
    logic [3:0] idle_pat;

    initial
    begin
        sclk_o   = 1'b0;
        cs_n_o   = 1'b1;
        drive0   = 1'b0;
        host_bit = 1'b0;
        idle_pat = 4'h5;
    end

    // undriven lanes wander so a stale value never passes for data
    always #3 idle_pat = ~idle_pat;

    always_comb
    begin
        for (int k = 0; k < 4; k++)
            lane_o[k] = dev_oe_i[k] ? dev_io_i[k] : ((k == 0 && drive0) ? host_bit : idle_pat[k]);
    end

    // ==============================
    // one framed transfer, clock idle outside the frame
    task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, input int lanes,
                        output logic [63:0] rx, output logic oe_seen);
        int i;
        rx      = '0;
        oe_seen = 1'b0;
        cs_n_o  = 1'b0;
        drive0  = 1'b1;
        #300;
        for (i = 0; i < ntx + nrx; i++)
        begin
            host_bit = (i < ntx) ? tx[ntx-1-i] : 1'b0;
            #3;
            sclk_o = 1'b1;
            if (i >= ntx)
            begin
                oe_seen = oe_seen | (|dev_oe_i);
                if (lanes == 4)
                    rx = (rx << 4) | 64'(lane_o);
                else if (lanes == 2)
                    rx = (rx << 2) | 64'(lane_o[1:0]);
                else
                    rx = (rx << 1) | 64'(lane_o[1]);
            end
            #1;
            if (i == ntx - 1 && nrx > 0)
                drive0 = 1'b0;
            #2;
            sclk_o = 1'b0;
        end
        #3;
        cs_n_o = 1'b1;
        drive0 = 1'b0;
        #800;
    endtask : xfer
endmodule : spi_host_model

// File: tb/serial_flash_status_and_read_cmds_tb.sv
// serial_flash_status_and_read_cmds_tb: self-checking bench for the flash command engine
`timescale 1ns/10ps
module serial_flash_status_and_read_cmds_tb;
    import sflash_pkg::*;
    localparam int         WCYC = 60;
    localparam logic [7:0] SEED = 8'ha5;

    logic        clk_i;
    logic        rst_i;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        busy;
    logic [15:0] status;
    logic [63:0] rx;
    logic        oe_seen;
    logic        busy_seen;
    int          mismatches;
    int          check_count;

    serial_flash_cmd #(.WRITE_CYCLES(WCYC), .ARRAY_SEED(SEED)) serial_flash_cmd_inst
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sclk_i   (sclk),
        .cs_n_i   (cs_n),
        .io_i     (io_in),
        .io_o     (io_out),
        .io_oe_o  (io_oe),
        .busy_o   (busy),
        .status_o (status)
    );

    spi_host_model spi_host_model_inst
    (
        .dev_io_i (io_out),
        .dev_oe_i (io_oe),
        .sclk_o   (sclk),
        .cs_n_o   (cs_n),
        .lane_o   (io_in)
    );

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i)
        if (busy === 1'b1)
            busy_seen <= 1'b1;

    // ==============================
    // helpers
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_flag(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_flag

    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, input int lanes);
        spi_host_model_inst.xfer(tx, ntx, nrx, lanes, rx, oe_seen);
    endtask : frame

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk_flag("busy_end", 1'b0, busy);
    endtask : wait_idle

    function automatic logic [7:0] eb(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ SEED;
    endfunction : eb

    // ==============================
    // scenarios
    task automatic t_latch();
        frame(64'(OP_RD_STAT1), 8, 8, 1);
        chk_word("stat_boot", 16'h0000, {status[15:8], rx[7:0]});
        frame(64'(OP_WR_ENABLE), 8, 0, 1);
        frame(64'h0ff, 8, 0, 1);
        frame(64'h0, 5, 0, 1);
        frame(64'(OP_RD_STAT1), 8, 8, 1);
        chk_word("latch_set", 16'h0002, 16'(rx[7:0]));
        frame(64'(OP_WR_DISABLE), 8, 0, 1);
        chk_word("latch_clr", 16'h0000, status);
    endtask : t_latch

    task automatic t_guarded_write();
        frame({OP_WR_STATUS, 8'h7c, 8'h02}, 24, 0, 1);
        chk_word("no_latch_wr", 16'h0000, status);
        frame(64'(OP_WR_ENABLE), 8, 0, 1);
        frame({OP_WR_STATUS, 12'h7c0}, 20, 0, 1);
        chk_word("bad_len_wr", 16'h0002, status);
        frame({OP_WR_STATUS, 8'h7f, 8'h02}, 24, 0, 1);
        chk_word("nv_busy", 16'h027f, status);
        frame(64'(OP_RD_STAT1), 8, 16, 1);
        chk_word("poll_busy", 16'h7f7f, rx[15:0]);
        frame({OP_READ, 24'h000000}, 32, 8, 1);
        chk_flag("read_busy", 1'b0, oe_seen);
        wait_idle();
        chk_word("nv_done", 16'h027c, status);
        frame(64'(OP_RD_STAT2), 8, 16, 1);
        chk_word("stat_two", 16'h0202, rx[15:0]);
    endtask : t_guarded_write

    task automatic t_reads();
        logic [7:0]  ops[4];
        int          ntx[4];
        int          ln[4];
        logic [23:0] a;
        ops = '{OP_READ, OP_FAST, OP_DUAL, OP_QUAD};
        ntx = '{32, 40, 40, 40};
        ln  = '{1, 1, 2, 4};
        a   = 24'h12ffff;
        for (int m = 0; m < 4; m++)
        begin
            frame({ops[m], a, 8'h00} >> (40 - ntx[m]), ntx[m], 16 / ln[m], ln[m]);
            chk_word("array", {eb(a), eb(a + 24'h1)}, rx[15:0]);
        end
    endtask : t_reads

    task automatic t_short_write();
        frame(64'(OP_WR_ENABLE), 8, 0, 1);
        frame({OP_WR_STATUS, 8'h00}, 16, 0, 1);
        wait_idle();
        chk_word("short_wr", 16'h0000, status);
        frame({OP_QUAD, 32'h0}, 40, 4, 4);
        chk_flag("quad_off", 1'b0, oe_seen);
    endtask : t_short_write

    task automatic t_volatile();
        busy_seen <= 1'b0;
        frame(64'(OP_VOL_ENABLE), 8, 0, 1);
        frame({OP_WR_STATUS, 8'h0c, 8'h4b}, 24, 0, 1);
        chk_word("vol_wr", 16'h4b0c, status);
        frame(64'(OP_VOL_ENABLE), 8, 0, 1);
        frame({OP_WR_STATUS, 8'h0c}, 16, 0, 1);
        chk_word("vol_short", 16'h090c, status);
        frame(64'(OP_VOL_ENABLE), 8, 0, 1);
        frame({OP_WR_STATUS, 16'h0000}, 24, 0, 1);
        chk_word("otp_keep", 16'h0900, status);
        chk_flag("vol_busy", 1'b0, busy_seen);
        frame(64'(OP_WR_ENABLE), 8, 0, 1);
        chk_word("pre_reset", 16'h0902, status);
        @(posedge clk_i);
        #1 rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk_word("power_up", 16'h0000, status);
    endtask : t_volatile

    initial
    begin
        clk_i       = 1'b0;
        rst_i       = 1'b1;
        busy_seen   <= 1'b0;
        mismatches  = 0;
        check_count = 0;
        repeat (12) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        t_latch();
        t_guarded_write();
        t_reads();
        t_short_write();
        t_volatile();
        wrap_up();
    end

    initial
    begin
        #500000;
        mismatches++;
        wrap_up();
    end
endmodule : serial_flash_status_and_read_cmds_tb
